// [verilog/ssi_pkg.sv]
`default_nettype none
package ssi_pkg;
    // ==================================================
    // mode select codes
    localparam logic [3:0] MODE_SLV7 = 4'h6;
    localparam logic [3:0] MODE_SLV10 = 4'h7;
    localparam logic [3:0] MODE_MST_IDLE = 4'hB;
    localparam logic [3:0] MODE_SLV7_SP = 4'hE;
    localparam logic [3:0] MODE_SLV10_SP = 4'hF;
    // ==================================================
    // byte framing
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E; // 11110 a9 a8 rw
    localparam logic [6:0] GENERAL_CALL = 7'h00;
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 32;
    // ==================================================
    // values after reset
    localparam logic [7:0] SHIFT_RST = 8'h00;
    localparam logic [3:0] CNT_RST = 4'h0;
    // ==================================================
    // grouped carriers
    typedef struct packed {
        logic port_enable;
        logic [3:0] mode_select;
    } ssi_ctrl_type;
    typedef struct packed {
        logic start_seen;
        logic stop_seen;
        logic read_write;
        logic update_address;
    } ssi_status_type;
    localparam ssi_status_type STATUS_RST = 4'h0;
endpackage
`default_nettype wire

// [verilog/ssi_slave.sv]
`timescale 1ns/1ps
`default_nettype none

// ==================================================
// receive fifo with a registered head stage
module ssi_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH]; // storage, depth must be a power of two
    logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic full_r, full_nxt, ov_r, ov_nxt;
    logic [WIDTH-1:0] od_r, od_nxt;
    logic push, load;

    // next pointers, count and head stage
    always_comb begin
        push = in_valid && !full_r;
        load = (cnt_r != '0) && (!ov_r || out_ready);
        wr_nxt = push ? wr_r + 1'b1 : wr_r;
        rd_nxt = load ? rd_r + 1'b1 : rd_r;
        cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
        // the head stage holds a word too, so it counts toward full
        full_nxt = (cnt_nxt + {{AW{1'b0}}, ov_nxt}) == (AW+1)'(DEPTH);
        ov_nxt = load ? 1'b1 : (out_ready ? 1'b0 : ov_r);
        od_nxt = load ? mem[rd_r] : od_r;
    end

    // registers only; memory carries no reset
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_r] <= in_data;
        end
        if (rst) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
            full_r <= 1'b0;
            ov_r <= 1'b0;
            od_r <= '0;
        end else begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            cnt_r <= cnt_nxt;
            full_r <= full_nxt;
            ov_r <= ov_nxt;
            od_r <= od_nxt;
        end
    end

    assign in_ready = !full_r;
    assign out_valid = ov_r;
    assign out_data = od_r;
endmodule // ssi_fifo

// ==================================================
// Overview of operation
// - match 7/10-bit own address, ignore general call
// - four-bit mode picks slave or master-idle flavours
// - pattern 1011 means firmware master, slave idle
// - port enable gates everything but the start/stop irq
// - pins open-drain only when directions are inputs
// - transmitter overrides data pin when driving
// - auto acknowledge, then load buffer from shifter
// - full or overflow: no ack, no load, irq
// - reading frees buffer; overflow cleared by software
// - after start, sample eight bits on clock rise
// - compare address bits at eighth falling edge
// - matched byte loads, acks, irq at ninth fall
// - ten-bit first byte is 11110 a9 a8 rw; rw 1 accepted only after a ten-bit match
// - ten-bit write address bytes set update flag, hold clock
// - write address clears read_write, buffers address
// - every byte but a foreign address or a master-nacked read raises irq; software clears it
// - read address sets read_write, acks, holds clock
// - buffer write loads shifter; release frees clock
// - transmit bits change on falling clock edges
// - master nack resets slave, waits new start
// - start/stop flags cleared on reset or disable
module ssi_slave
    import ssi_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire ssi_ctrl_type ctrl,
    input wire logic dir_scl,
    input wire logic dir_sda,
    input wire logic [7:0] own_addr_wdata,
    input wire logic own_addr_wr,
    input wire logic [7:0] buf_wdata,
    input wire logic buf_wr,
    input wire logic rx_ready,
    input wire logic clock_release_set,
    input wire logic irq_clr,
    input wire logic overflow_clr,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic scl_oe_n,
    output logic sda_o,
    output logic sda_oe_n,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic buffer_full,
    output logic receive_overflow,
    output logic clock_release,
    output logic serial_irq_flag,
    output ssi_status_type status
);
    typedef enum logic [2:0] {
        st_idle, st_wait, st_rx, st_ack, st_tx, st_txack
    } ssi_state_type;

    // ==================================================
    // pin synchronisers and edge finders
    logic [2:0] scl_r, sda_r; // [0] is first stage only
    logic scl_rise, scl_fall, start_det, stop_det;
    always_ff @(posedge clk) begin
        if (rst) begin
            scl_r <= 3'h7;
            sda_r <= 3'h7;
        end else begin
            scl_r <= {scl_r[1:0], scl_i};
            sda_r <= {sda_r[1:0], sda_i};
        end
    end
    // edges look at stages 1 and 2 only
    always_comb begin
        scl_rise = scl_r[1] && !scl_r[2];
        scl_fall = !scl_r[1] && scl_r[2];
        start_det = scl_r[1] && scl_r[2] && !sda_r[1] && sda_r[2];
        stop_det = scl_r[1] && scl_r[2] && sda_r[1] && !sda_r[2];
    end

    // ==================================================
    // receive buffer
    logic push_r, push_nxt, fifo_rdy;
    logic [7:0] sh_r, sh_nxt; // bit_shifter
    ssi_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(DEPTH)) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(push_r),
        .in_data(sh_r),
        .in_ready(fifo_rdy),
        .out_valid(rx_valid),
        .out_data(rx_data),
        .out_ready(rx_ready) // popping frees room
    );
    assign buffer_full = !fifo_rdy; // straight from the fifo flag

    // ==================================================
    // protocol state
    ssi_state_type st_r, st_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] own_r, own_nxt;
    logic first_r, first_nxt; // next byte is first address byte
    logic low_r, low_nxt; // next byte is ten-bit low address
    logic ten_r, ten_nxt; // ten-bit address matched this frame
    logic ack_r, ack_nxt, tx_r, tx_nxt, adr_r, adr_nxt, ua_ev_r, ua_ev_nxt;
    logic irq_r, irq_nxt, ovf_r, ovf_nxt, ckp_r, ckp_nxt;
    ssi_status_type stat_r, stat_nxt;
    logic sda_drv_nxt, scl_drv_nxt, sda_oe_n_r, scl_oe_n_r;
    logic en, slv, sp_mode, ten_mode, m7, rw;

    // next-state logic for the whole slave
    always_comb begin
        en = ctrl.port_enable;
        ten_mode = ctrl.mode_select == MODE_SLV10
            || ctrl.mode_select == MODE_SLV10_SP;
        slv = ten_mode || ctrl.mode_select == MODE_SLV7
            || ctrl.mode_select == MODE_SLV7_SP; // idle in 1011
        sp_mode = ctrl.mode_select == MODE_SLV7_SP
            || ctrl.mode_select == MODE_SLV10_SP
            || ctrl.mode_select == MODE_MST_IDLE;
        // general call never matches
        m7 = sh_r[7:1] == own_r[7:1] && sh_r[7:1] != GENERAL_CALL;
        rw = sh_r[0];
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        own_nxt = own_addr_wr ? own_addr_wdata : own_r;
        first_nxt = first_r;
        low_nxt = low_r;
        ten_nxt = ten_r;
        ack_nxt = ack_r;
        tx_nxt = tx_r;
        adr_nxt = adr_r;
        ua_ev_nxt = 1'b0;
        push_nxt = 1'b0;
        stat_nxt = stat_r;
        irq_nxt = irq_r && !irq_clr;
        ovf_nxt = ovf_r && !overflow_clr; // software only
        ckp_nxt = ckp_r || clock_release_set;
        if (own_addr_wr) begin
            stat_nxt.update_address = 1'b0; // releases clock
        end
        case (st_r)
            st_idle, st_wait: begin
                // nothing to do until a start shows up
            end
            st_rx: begin
                if (scl_rise) begin
                    sh_nxt = {sh_r[6:0], sda_r[2]};
                    cnt_nxt = cnt_r + 4'h1;
                end else if (scl_fall && cnt_r == BITS_PER_BYTE) begin
                    // eighth fall: decide ack
                    adr_nxt = first_r || low_r;
                    tx_nxt = 1'b0;
                    if (first_r && ten_mode) begin
                        // own_r holds 11110 a9 a8 here
                        ack_nxt = m7 && sh_r[7:3] == TEN_BIT_PREFIX
                            && (!rw || ten_r);
                        tx_nxt = rw;
                    end else if (first_r) begin
                        ack_nxt = m7;
                        tx_nxt = rw;
                    end else if (low_r) begin
                        ack_nxt = sh_r == own_r;
                    end else begin
                        ack_nxt = 1'b1;
                    end
                    if (!ack_nxt && adr_nxt) begin
                        st_nxt = st_wait; // not addressed
                    end else begin
                        // busy buffer withholds ack
                        ack_nxt = !buffer_full && !ovf_r;
                        st_nxt = st_ack;
                    end
                end
            end
            st_ack: begin
                if (scl_fall) begin
                    irq_nxt = 1'b1; // ninth fall
                    cnt_nxt = CNT_RST;
                    first_nxt = 1'b0;
                    low_nxt = 1'b0;
                    st_nxt = st_rx;
                    if (ack_r) begin
                        push_nxt = 1'b1;
                        if (adr_r) begin
                            stat_nxt.read_write = tx_r;
                        end
                        if (adr_r && ten_mode && !tx_r) begin
                            ua_ev_nxt = 1'b1;
                            low_nxt = first_r;
                            ten_nxt = low_r;
                        end
                        if (tx_r) begin
                            ckp_nxt = 1'b0; // stretch
                            st_nxt = st_tx;
                        end
                    end else begin
                        if (buffer_full) begin
                            ovf_nxt = 1'b1; // set wins
                        end
                        if (adr_r) begin
                            st_nxt = st_wait;
                        end
                    end
                end
            end
            st_tx: begin
                if (scl_fall && ckp_r) begin
                    sh_nxt = {sh_r[6:0], 1'b1};
                    cnt_nxt = cnt_r + 4'h1;
                    if (cnt_r == BITS_PER_BYTE - 4'h1) begin
                        st_nxt = st_txack;
                    end
                end
            end
            st_txack: begin
                if (scl_rise && sda_r[2]) begin
                    st_nxt = st_wait; // master nack
                    stat_nxt.read_write = 1'b0;
                    stat_nxt.update_address = 1'b0;
                end else if (scl_fall) begin
                    irq_nxt = 1'b1;
                    ckp_nxt = 1'b0; // hold for next byte
                    cnt_nxt = CNT_RST;
                    st_nxt = st_tx;
                end
            end
            default: st_nxt = st_idle;
        endcase
        if (buf_wr) begin
            sh_nxt = buf_wdata;
        end
        if (ua_ev_r) begin
            stat_nxt.update_address = 1'b1; // set wins over the address-write and nack clears; disable still clears it
        end
        if (start_det) begin
            stat_nxt.start_seen = 1'b1;
            stat_nxt.stop_seen = 1'b0;
            st_nxt = slv ? st_rx : st_idle;
            cnt_nxt = CNT_RST;
            first_nxt = 1'b1;
            low_nxt = 1'b0;
        end
        if (stop_det) begin
            stat_nxt.stop_seen = 1'b1;
            stat_nxt.start_seen = 1'b0;
            st_nxt = st_idle;
            ten_nxt = 1'b0;
        end
        if ((start_det || stop_det) && sp_mode) begin
            irq_nxt = 1'b1;
        end
        if (!en) begin
            // disable clears the bus view
            st_nxt = st_idle;
            stat_nxt = STATUS_RST;
            ten_nxt = 1'b0;
        end
        // pin drive, only as open drain
        sda_drv_nxt = (st_nxt == st_ack && ack_nxt)
            || (st_nxt == st_tx && !sh_nxt[7]);
        scl_drv_nxt = (st_nxt == st_tx && !ckp_nxt)
            || stat_nxt.update_address;
        sda_drv_nxt = sda_drv_nxt && en && dir_sda;
        scl_drv_nxt = scl_drv_nxt && en && dir_scl;
    end

    // register every piece of state
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= st_idle;
            cnt_r <= CNT_RST;
            sh_r <= SHIFT_RST;
            own_r <= SHIFT_RST;
            first_r <= 1'b0;
            low_r <= 1'b0;
            ten_r <= 1'b0;
            ack_r <= 1'b0;
            tx_r <= 1'b0;
            adr_r <= 1'b0;
            ua_ev_r <= 1'b0;
            push_r <= 1'b0;
            stat_r <= STATUS_RST;
            irq_r <= 1'b0;
            ovf_r <= 1'b0;
            ckp_r <= 1'b0;
            sda_oe_n_r <= 1'b1;
            scl_oe_n_r <= 1'b1;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            own_r <= own_nxt;
            first_r <= first_nxt;
            low_r <= low_nxt;
            ten_r <= ten_nxt;
            ack_r <= ack_nxt;
            tx_r <= tx_nxt;
            adr_r <= adr_nxt;
            ua_ev_r <= ua_ev_nxt;
            push_r <= push_nxt;
            stat_r <= stat_nxt;
            irq_r <= irq_nxt;
            ovf_r <= ovf_nxt;
            ckp_r <= ckp_nxt;
            sda_oe_n_r <= !sda_drv_nxt;
            scl_oe_n_r <= !scl_drv_nxt;
        end
    end

    // open-drain outputs always pull low when enabled
    always_ff @(posedge clk) begin
        scl_o <= 1'b0;
        sda_o <= 1'b0;
    end
    assign scl_oe_n = scl_oe_n_r;
    assign sda_oe_n = sda_oe_n_r;
    assign receive_overflow = ovf_r;
    assign clock_release = ckp_r;
    assign serial_irq_flag = irq_r;
    assign status = stat_r;
endmodule // ssi_slave
`default_nettype wire

// [bench/ssi_slave_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// port checker for the two-wire slave
module ssi_slave_asserts
    import ssi_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire ssi_ctrl_type ctrl,
    input wire logic dir_scl,
    input wire logic dir_sda,
    input wire logic clock_release_set,
    input wire logic irq_clr,
    input wire logic overflow_clr,
    input wire logic scl_i,
    input wire logic scl_oe_n,
    input wire logic sda_oe_n,
    input wire logic buffer_full,
    input wire logic receive_overflow,
    input wire logic serial_irq_flag,
    input wire ssi_status_type status
);
    // one domain, so clock and reset are given once
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ==================================================
    // named steps of a read transfer
    sequence rd_addr_s;
        $rose(status.read_write);
    endsequence
    sequence held_s;
        ##[0:3] !scl_oe_n;
    endsequence
    sequence freed_s;
        ##[1:4] scl_oe_n;
    endsequence
    // ==================================================
    // assertions
    chk_dir_quiet: assert property (
        (!dir_scl && !dir_sda) [*2] |-> scl_oe_n && sda_oe_n)
        else $error("pin driven while set as output");
    chk_off_quiet: assert property (
        !ctrl.port_enable [*3] |-> scl_oe_n && sda_oe_n)
        else $error("pin driven while port disabled");
    chk_flags_off: assert property (
        !ctrl.port_enable [*3] |-> !status.start_seen && !status.stop_seen)
        else $error("start or stop flag kept while disabled");
    chk_ovf_sticky: assert property (
        receive_overflow && !overflow_clr && ctrl.port_enable
        |=> receive_overflow) else $error("overflow lost without clear");
    chk_irq_sticky: assert property (
        serial_irq_flag && !irq_clr && ctrl.port_enable
        |=> serial_irq_flag) else $error("irq lost without clear");
    chk_ovf_cause: assert property (
        $rose(receive_overflow) |-> buffer_full || $past(buffer_full))
        else $error("overflow set with room in buffer");
    chk_ovf_irq: assert property (
        $rose(receive_overflow) |-> ##[0:2] serial_irq_flag)
        else $error("refused byte gave no irq");
    chk_full_noack: assert property (
        $fell(sda_oe_n) && !status.read_write
        |-> !buffer_full && !receive_overflow)
        else $error("ack pulled while full or overflowed");
    chk_rd_hold: assert property (rd_addr_s |-> held_s)
        else $error("clock not held after read address");
    chk_rel_hold: assert property (
        status.read_write && !scl_oe_n && clock_release_set |-> freed_s)
        else $error("clock not freed after release");
    chk_tx_stable: assert property (
        status.read_write && scl_i && $past(scl_i) |-> $stable(sda_oe_n))
        else $error("data changed while clock high");
endmodule // ssi_slave_asserts
bind ssi_slave ssi_slave_asserts u_chk (.clk, .rst, .ctrl, .dir_scl,
    .dir_sda, .clock_release_set, .irq_clr, .overflow_clr, .scl_i,
    .scl_oe_n, .sda_oe_n, .buffer_full, .receive_overflow,
    .serial_irq_flag, .status);
`default_nettype wire

// [bench/ssi_master_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// behavioural bus master; pull outputs, pull-ups on the wires
module ssi_master_model (
    input wire logic scl,
    input wire logic sda,
    output logic scl_pull,
    output logic sda_pull
);
    // low and high phases make a 320 ns clock
    localparam int T_LOW = 240;
    localparam int T_HIGH = 80;
    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end
    // free the clock and wait while the slave stretches it
    task automatic rise;
        scl_pull = 1'b0;
        for (int i = 0; i < 4000 && scl !== 1'b1; i++) #20;
        #(T_HIGH);
    endtask
    // one bit: data changes only while the clock is low
    task automatic bit_io(input logic b, output logic s);
        #(T_LOW / 4);
        sda_pull = !b;
        #(T_LOW * 3 / 4);
        rise();
        s = sda;
        scl_pull = 1'b1;
    endtask
    // data falls while clock high
    task automatic start;
        sda_pull = 1'b0;
        #(T_LOW);
        rise();
        sda_pull = 1'b1;
        #(T_HIGH);
        scl_pull = 1'b1;
    endtask
    // data rises while clock high
    task automatic stop;
        #(T_LOW / 4);
        sda_pull = 1'b1;
        #(T_LOW * 3 / 4);
        rise();
        sda_pull = 1'b0;
        #(T_LOW);
    endtask
    // msb first, then sample the slave's answer
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(b[i], s);
        bit_io(1'b1, s);
        ack = !s;
    endtask
    // sda left free for the slave; nak ends the transfer
    task automatic rbyte(output logic [7:0] b, input logic nak);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            b[i] = s;
        end
        bit_io(nak, s);
    endtask
endmodule // ssi_master_model
`default_nettype wire

// [bench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import ssi_pkg::*;
    // ==================================================
    // stimulus and observed signals
    logic clk = 1'b0;
    logic rst = 1'b1;
    ssi_ctrl_type ctrl = '0;
    logic dir_scl = 1'b1;
    logic dir_sda = 1'b1;
    logic [7:0] own_addr_wdata = 8'h00;
    logic [7:0] buf_wdata = 8'h00;
    logic rx_ready = 1'b0;
    logic [4:0] pl = 5'h00; // pulse inputs, one bit each
    logic scl_oe_n, sda_oe_n, rx_valid, buffer_full, receive_overflow;
    logic clock_release, serial_irq_flag, scl_o, sda_o;
    logic [7:0] rx_data;
    ssi_status_type status;
    wire logic m_scl, m_sda, scl_w, sda_w;
    logic [7:0] exp_q [$]; // bytes the fifo should hand over
    logic [3:0] modes [5] = '{MODE_SLV7, MODE_SLV10, MODE_SLV7_SP,
        MODE_SLV10_SP, MODE_MST_IDLE};
    logic sp, ak;
    logic [7:0] tx, got, exp_b;
    int err_count = 0;
    int tests_run = 0;
    always #20 clk = !clk;
    // open drain wires with pull-ups
    assign scl_w = !(m_scl || !scl_oe_n);
    assign sda_w = !(m_sda || !sda_oe_n);
    // ==================================================
    // design and far-side master
    ssi_slave #(.DEPTH(4)) DUT (.clk, .rst, .ctrl, .dir_scl, .dir_sda,
        .own_addr_wdata, .own_addr_wr(pl[0]), .buf_wdata, .buf_wr(pl[1]),
        .rx_ready, .clock_release_set(pl[2]), .irq_clr(pl[3]),
        .overflow_clr(pl[4]), .scl_i(scl_w), .sda_i(sda_w), .scl_o,
        .scl_oe_n, .sda_o, .sda_oe_n, .rx_valid, .rx_data, .buffer_full,
        .receive_overflow, .clock_release, .serial_irq_flag, .status);
    ssi_master_model partner (.scl(scl_w), .sda(sda_w), .scl_pull(m_scl),
        .sda_pull(m_sda));
    // ==================================================
    // shared tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t seen %h expected %h", $time, seen,
                exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic pulse(input int i);
        @(posedge clk) pl[i] <= 1'b1;
        @(posedge clk) pl[i] <= 1'b0;
    endtask
    // one byte from the master; room left for the pins to sync
    task automatic wr(input logic [7:0] b, input logic ak_exp);
        logic s;
        if (ak_exp) exp_q.push_back(b);
        partner.wbyte(b, s);
        tick(6);
        check({7'h00, s}, {7'h00, ak_exp});
    endtask
    // looks between edges, then hands back on a rising edge
    task automatic wait_hold;
        @(negedge clk);
        for (int n = 0; n < 200 && scl_oe_n !== 1'b0; n++) @(negedge clk);
        check({7'h00, scl_oe_n}, 8'h00);
        @(posedge clk);
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ==================================================
    // fifo watcher: oldest note against each handed-over byte
    // sampled half a cycle after launch, while the handshake stands
    always @(negedge clk) begin
        if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
            exp_b = exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX;
            check(rx_data, exp_b);
        end
    end
    // eleven frames of a few microseconds each
    initial begin
        #3000000;
        err_count++;
        close_out();
    end
    // ==================================================
    // main sequence
    initial begin
        void'($urandom(32'h48045B1C));
        tick(6);
        rst <= 1'b0;
        rx_ready <= 1'b1;
        ctrl <= {1'b1, MODE_SLV7};
        own_addr_wdata <= 8'hA4;
        pulse(0);
        // every mode: start/stop irq and address answer
        foreach (modes[i]) begin
            sp = modes[i] inside {MODE_SLV7_SP, MODE_SLV10_SP, MODE_MST_IDLE};
            ak = modes[i] inside {MODE_SLV7, MODE_SLV7_SP};
            ctrl.mode_select <= modes[i];
            pulse(3);
            partner.start();
            tick(6);
            check({4'h0, status}, 8'h08);
            check({7'h00, serial_irq_flag}, {7'h00, sp});
            pulse(3);
            wr(8'hA4, ak);
            partner.stop();
            tick(6);
            check({4'h0, status}, 8'h04);
            check({7'h00, serial_irq_flag}, {7'h00, sp | ak});
        end
        // write with random data, irq per byte
        ctrl.mode_select <= MODE_SLV7;
        partner.start();
        for (int i = 0; i < 4; i++) begin
            pulse(3);
            wr(i == 0 ? 8'hA4 : 8'($urandom), 1'b1);
            check({4'h0, status}, 8'h08);
            check({7'h00, serial_irq_flag}, 8'h01);
        end
        partner.stop();
        // general call and a foreign address are ignored
        foreach (modes[i]) begin
            if (i < 2) begin
                partner.start();
                wr(i == 0 ? {GENERAL_CALL, 1'b0} : 8'hB4, 1'b0);
                partner.stop();
            end
        end
        // fill the fifo until it refuses, then drain it
        tick(1);
        rx_ready <= 1'b0;
        partner.start();
        for (int i = 0; i < 4; i++) wr(i == 0 ? 8'hA4 : 8'($urandom), 1'b1);
        check({7'h00, buffer_full}, 8'h01);
        pulse(3);
        wr(8'($urandom), 1'b0);
        check({6'h00, receive_overflow, serial_irq_flag}, 8'h03);
        partner.stop();
        tick(1);
        rx_ready <= 1'b1;
        tick(20);
        check({6'h00, buffer_full, receive_overflow}, 8'h01);
        pulse(4);
        tick(2);
        check({7'h00, receive_overflow}, 8'h00);
        // read: clock held, byte loaded, release, ack then nak
        partner.start();
        wr(8'hA5, 1'b1);
        for (int i = 0; i < 2; i++) begin
            wait_hold();
            check({3'h0, clock_release, status}, 8'h0A);
            tx = 8'($urandom);
            buf_wdata <= tx;
            pulse(1);
            pulse(2);
            partner.rbyte(got, i == 1);
            check(got, tx);
        end
        tick(8);
        check({7'h00, status.read_write}, 8'h00);
        partner.stop();
        // ten-bit write: software swaps the address halves
        tick(1);
        ctrl.mode_select <= MODE_SLV10;
        own_addr_wdata <= 8'hF4;
        pulse(0);
        partner.start();
        wr(8'hF4, 1'b1);
        check({3'h0, scl_oe_n, status}, 8'h09);
        own_addr_wdata <= 8'hA5;
        pulse(0);
        tick(2);
        check({3'h0, scl_oe_n, status}, 8'h18);
        wr(8'hA5, 1'b1);
        check({3'h0, scl_oe_n, status}, 8'h09);
        own_addr_wdata <= 8'hF4;
        pulse(0);
        wr(8'($urandom), 1'b1);
        partner.stop();
        // both direction bits move in one write
        tick(1);
        dir_scl <= 1'b0;
        dir_sda <= 1'b0;
        tick(4);
        dir_scl <= 1'b1;
        dir_sda <= 1'b1;
        ctrl.port_enable <= 1'b0;
        tick(4);
        check({4'h0, status}, 8'h00);
        check({6'h00, scl_o, sda_o}, 8'h00);
        close_out();
    end
endmodule // testbench
`default_nettype wire
